// ### event_logic_consts.vh
// Register offsets, field positions and reset values of the general-purpose event logic
`ifndef EVENT_LOGIC_CONSTS_VH
`define EVENT_LOGIC_CONSTS_VH
`define PM_DATA_OFFSET 8'ha7
`define STATUS_LO_OFFSET 8'ha8
`define STATUS_HI_OFFSET 8'ha9
`define ENABLE_LO_OFFSET 8'haa
`define ENABLE_HI_OFFSET 8'hab
`define PM_DATA_VALUE 8'h00
`define REG16_RESET 16'h0000
`define EVENT_BITS_MASK 16'h891f
`define VIDEO_BIT 15
`define POWER_BIT 11
`define VPP12_BIT 8
`define INPUT_COUNT 5
`define INPUT_RESET 5'h00
`define TERMINAL_COUNT 7
`endif

// ### input_change_detect.v
// Synchroniser and change detector for the general-purpose input terminals
`timescale 1ns/1ns
module input_change_detect (
    input wire ref_clk, // Controller clock
    input wire reset, // Asynchronous reset, active high
    input wire [4:0] pins_in, // Raw terminal levels
    output reg [4:0] level_out, // Synchronised levels
    output wire [4:0] change_pulse // One-cycle pulse per changed input
);
`include "event_logic_consts.vh"
    reg [4:0] meta_reg;
    reg [4:0] sync_reg;
    reg primed_reg;

    // Two-stage synchroniser then one history stage
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_reg <= `INPUT_RESET;
            sync_reg <= `INPUT_RESET;
            level_out <= `INPUT_RESET;
            primed_reg <= 1'b0;
        end else begin
            meta_reg <= pins_in;
            sync_reg <= meta_reg;
            level_out <= sync_reg;
            primed_reg <= 1'b1;
        end
    end

    // Compare current sample with the previous one; masked only until the first clock after reset, so a pin high through reset still reports a change
    genvar i;
    generate
        for (i = 0; i < `INPUT_COUNT; i = i + 1) begin : g_chg
            assign change_pulse[i] = primed_reg & (sync_reg[i] ^ level_out[i]);
        end
    endgenerate
endmodule // input_change_detect

// ### general_purpose_event_logic.v
// General-purpose event status, enable and event output logic
`timescale 1ns/1ns
module general_purpose_event_logic (
    input wire ref_clk, // Controller clock, 50 MHz
    input wire reset, // Asynchronous reset, active high
    input wire [7:0] cfg_addr, // Configuration byte address
    input wire cfg_wr, // Byte write strobe
    input wire [7:0] cfg_wdata, // Byte write data
    output reg [7:0] cfg_rdata, // Byte read data, registered
    input wire video_port_enable_bit, // Card control video-port enable level
    input wire power_change, // Pulse: software wrote new Vcc or Vpp setting
    input wire vpp_is_12v, // Requested Vpp is 12 V
    input wire [4:0] gp_input_pins, // Terminals 5,4,2,1,0 input levels
    input wire [4:0] gp_input_selected, // Each terminal configured as general input
    input wire [6:0] event_pin_selected, // Terminals 6..0 configured for event output
    output reg general_event_out_n, // Internal event, active low
    output reg [6:0] multipurpose_terminal_out, // Event level on terminals 6..0
    output reg [6:0] multipurpose_terminal_oe, // Drive enable on terminals 6..0
    output wire [4:0] gp_input_level // Synchronised input levels
);
`include "event_logic_consts.vh"
    reg [15:0] event_status_flags;
    reg [15:0] event_enable_mask;
    reg video_prev_reg;
    reg vpp12_prev_reg;
    reg history_ok_reg;
    reg [15:0] set_vec;
    reg [15:0] clr_vec;
    reg [15:0] gate_vec;
    reg [15:0] status_next;
    reg [15:0] enable_next;
    reg event_active;
    wire [4:0] input_changed;
    integer k;

    input_change_detect u_inputs (
        .ref_clk(ref_clk),
        .reset(reset),
        .pins_in(gp_input_pins),
        .level_out(gp_input_level),
        .change_pulse(input_changed)
    );

    // History of the control levels to find changes
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            video_prev_reg <= 1'b0;
            vpp12_prev_reg <= 1'b0;
            history_ok_reg <= 1'b0;
        end else begin
            video_prev_reg <= video_port_enable_bit;
            vpp12_prev_reg <= vpp_is_12v;
            history_ok_reg <= 1'b1;
        end
    end

    // Event set vector, independent of enables
    always @* begin
        set_vec = `REG16_RESET;
        set_vec[`VIDEO_BIT] = history_ok_reg & (video_port_enable_bit ^ video_prev_reg);
        set_vec[`POWER_BIT] = power_change;
        set_vec[`VPP12_BIT] = history_ok_reg & (vpp_is_12v ^ vpp12_prev_reg);
        set_vec[`INPUT_COUNT-1:0] = input_changed;
    end

    // Write-one-to-clear with set winning; enables written per byte
    always @* begin
        clr_vec = `REG16_RESET;
        enable_next = event_enable_mask;
        if (cfg_wr) begin
            if (cfg_addr == `STATUS_LO_OFFSET)
                clr_vec[7:0] = cfg_wdata;
            if (cfg_addr == `STATUS_HI_OFFSET)
                clr_vec[15:8] = cfg_wdata;
            if (cfg_addr == `ENABLE_LO_OFFSET)
                enable_next[7:0] = cfg_wdata;
            if (cfg_addr == `ENABLE_HI_OFFSET)
                enable_next[15:8] = cfg_wdata;
        end
        status_next = ((event_status_flags & ~clr_vec) | set_vec) & `EVENT_BITS_MASK;
        enable_next = enable_next & `EVENT_BITS_MASK;
    end

    // Status and enable registers
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            event_status_flags <= `REG16_RESET;
            event_enable_mask <= `REG16_RESET;
        end else begin
            event_status_flags <= status_next;
            event_enable_mask <= enable_next;
        end
    end

    // Enabled status gated; input enables need the general-input configuration
    always @* begin
        gate_vec = event_enable_mask;
        for (k = 0; k < `INPUT_COUNT; k = k + 1) begin
            gate_vec[k] = event_enable_mask[k] & gp_input_selected[k];
        end
        event_active = |(event_status_flags & gate_vec);
    end

    // Registered active-low event output and terminal drive
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            general_event_out_n <= 1'b1;
            multipurpose_terminal_out <= 7'h7f;
            multipurpose_terminal_oe <= 7'h00;
        end else begin
            general_event_out_n <= ~event_active;
            multipurpose_terminal_out <= {`TERMINAL_COUNT{~event_active}};
            multipurpose_terminal_oe <= event_pin_selected;
        end
    end

    // Registered read data
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cfg_rdata <= `PM_DATA_VALUE;
        end else begin
            case (cfg_addr)
                `PM_DATA_OFFSET: cfg_rdata <= `PM_DATA_VALUE;
                `STATUS_LO_OFFSET: cfg_rdata <= event_status_flags[7:0];
                `STATUS_HI_OFFSET: cfg_rdata <= event_status_flags[15:8];
                `ENABLE_LO_OFFSET: cfg_rdata <= event_enable_mask[7:0];
                `ENABLE_HI_OFFSET: cfg_rdata <= event_enable_mask[15:8];
                default: cfg_rdata <= `PM_DATA_VALUE;
            endcase
        end
    end
endmodule // general_purpose_event_logic

// ### event_logic_properties.sv
// Concurrent checks on the general-purpose event logic ports
`timescale 1ns/1ns
module event_logic_properties (
    input wire ref_clk,
    input wire reset,
    input wire [7:0] cfg_addr,
    input wire cfg_wr,
    input wire [7:0] cfg_wdata,
    input wire [7:0] cfg_rdata,
    input wire [4:0] gp_input_pins,
    input wire [4:0] gp_input_selected,
    input wire [6:0] event_pin_selected,
    input wire general_event_out_n,
    input wire [6:0] multipurpose_terminal_oe,
    input wire [4:0] gp_input_level
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    pm_data_zero_a: assert property ($past(cfg_addr) == 8'ha7 |-> cfg_rdata == 8'h00)
        else $error("pm data not zero");
    unmapped_zero_a: assert property ($past(cfg_addr) < 8'ha7 || $past(cfg_addr) > 8'hab
        |-> cfg_rdata == 8'h00) else $error("unmapped read not zero");
    low_reserved_a: assert property ($past(cfg_addr) == 8'ha8 || $past(cfg_addr) == 8'haa
        |-> cfg_rdata[7:5] == 3'h0) else $error("low reserved bits set");
    high_reserved_a: assert property ($past(cfg_addr) == 8'ha9 || $past(cfg_addr) == 8'hab
        |-> (cfg_rdata & 8'h76) == 8'h00) else $error("high reserved bits set");
    mask_low_a: assert property (cfg_wr && cfg_addr == 8'haa ##1 !cfg_wr && cfg_addr == 8'haa
        |=> cfg_rdata == ($past(cfg_wdata, 2) & 8'h1f)) else $error("low mask readback");
    mask_high_a: assert property (cfg_wr && cfg_addr == 8'hab ##1 !cfg_wr && cfg_addr == 8'hab
        |=> cfg_rdata == ($past(cfg_wdata, 2) & 8'h89)) else $error("high mask readback");
    pin_drive_a: assert property (!$past(reset)
        |-> multipurpose_terminal_oe == $past(event_pin_selected)) else $error("drive enable");
    input_sync_a: assert property (!$past(reset) && !$past(reset, 2) && !$past(reset, 3)
        |-> gp_input_level == $past(gp_input_pins, 3)) else $error("input sync delay");
    event_hold_a: assert property ($rose(general_event_out_n) |-> $past(cfg_wr, 2)
        || $past(gp_input_selected) != $past(gp_input_selected, 2)) else $error("event dropped");
endmodule // event_logic_properties
bind general_purpose_event_logic event_logic_properties chk (.*);

// ### pm_event_sink.sv
// Power-management event input model on the multipurpose terminals
`timescale 1ns/1ns
module pm_event_sink (
    input wire ref_clk, // Clock
    input wire [6:0] pin_level, // Resolved terminal levels
    output reg event_seen // Low level seen on a terminal
);
    // Samples the active-low event request
    always @(posedge ref_clk) begin
        event_seen <= ~&pin_level;
    end
endmodule // pm_event_sink

// ### general_purpose_event_logic_bench.sv
// Self-checking bench of the general-purpose event logic
`timescale 1ns/1ns
module general_purpose_event_logic_bench;
    reg ref_clk = 0, reset = 1, cfg_wr = 0, power_change = 0;
    reg video_port_enable_bit = 0, vpp_is_12v = 0, o;
    reg [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00;
    reg [4:0] gp_input_pins = 5'h00, gp_input_selected = 5'h00;
    reg [6:0] event_pin_selected = 7'h00;
    reg [15:0] exp_sts, exp_en;
    wire [7:0] cfg_rdata;
    wire general_event_out_n, event_seen;
    wire [6:0] multipurpose_terminal_out, multipurpose_terminal_oe;
    wire [4:0] gp_input_level;
    int fail_count = 0, n_compared = 0, cycles = 0;
    general_purpose_event_logic DUT (.*);
    // Terminals are pulled up where not driven
    pm_event_sink sink (.ref_clk(ref_clk), .event_seen(event_seen),
        .pin_level(multipurpose_terminal_out | ~multipurpose_terminal_oe));
    initial forever #10 ref_clk = ~ref_clk;
    // Cuts a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task chk(input [15:0] got, input [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge ref_clk);
        cfg_wr <= 1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge ref_clk);
        cfg_wr <= 0;
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        @(posedge ref_clk);
        cfg_addr <= a;
        @(posedge ref_clk);
        #1 chk({8'h00, cfg_rdata}, {8'h00, exp});
    endtask
    task rd16(input [7:0] a, input [15:0] exp);
        rd(a, exp[7:0]);
        rd(a + 8'h01, exp[15:8]);
    endtask
    // Expected event output from flags, masks and general-input selection
    function exp_out(input [15:0] s, input [15:0] e, input [4:0] sel);
        exp_out = ~|(s & e & {11'h7ff, sel});
    endfunction
    function [15:0] flag_of(input int k);
        flag_of = 16'h0001 << (k < 5 ? k : k == 5 ? 15 : k == 6 ? 11 : 8);
    endfunction
    task report_and_stop;
        $display("Mismatches %0d, compares %0d", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Reset values, then random single events with random masks
    initial begin
        int k;
        reg [15:0] r;
        r = $urandom(73);
        repeat (2) @(posedge ref_clk);
        reset <= 0;
        rd(8'ha7, 8'h00);
        rd16(8'ha8, 16'h0000);
        rd16(8'haa, 16'h0000);
        rd(8'ha6, 8'h00);
        rd(8'hac, 8'h00);
        wr(8'ha7, 8'hff);
        rd(8'ha7, 8'h00);
        repeat (24) begin
            k = $urandom % 8;
            r = $urandom;
            gp_input_selected <= r[4:0];
            event_pin_selected <= r[11:5];
            r = $urandom;
            exp_en = r & 16'h891f;
            wr(8'haa, r[7:0]);
            rd(8'haa, exp_en[7:0]);
            wr(8'hab, r[15:8]);
            rd(8'hab, exp_en[15:8]);
            exp_sts = flag_of(k);
            @(posedge ref_clk);
            case (k)
                5: video_port_enable_bit <= ~video_port_enable_bit;
                6: power_change <= 1;
                7: vpp_is_12v <= ~vpp_is_12v;
                default: gp_input_pins[k] <= ~gp_input_pins[k];
            endcase
            @(posedge ref_clk) power_change <= 0;
            repeat (6) @(posedge ref_clk);
            #1 o = exp_out(exp_sts, exp_en, gp_input_selected);
            chk(general_event_out_n, o);
            chk(event_seen, !o && event_pin_selected != 7'h00);
            chk(gp_input_level, gp_input_pins);
            wr(8'ha8, 8'h00);
            wr(8'ha9, 8'h00);
            rd16(8'ha8, exp_sts);
            wr(8'ha8, 8'hff);
            wr(8'ha9, 8'hff);
            rd16(8'ha8, 16'h0000);
            chk(general_event_out_n, 1'b1);
        end
        report_and_stop();
    end
endmodule // general_purpose_event_logic_bench
